/* File: pkg/vsp_cfg.svh */
`ifndef VSP_CFG_SVH
`define VSP_CFG_SVH

// Register offsets inside the upstream port
`define VSP_ADDR_W         12
`define VSP_OFS_OUT_DATA   12'hA68
`define VSP_OFS_IRQ_LEVEL  12'hA6C
`define VSP_OFS_IRQ_STATE  12'hA70

// Slot and pin counts, field layout
`define VSP_SLOT_NUM       8
`define VSP_PIN_NUM        8
`define VSP_FIELD_W        8
`define VSP_OWNER_W        4
`define VSP_SLOT_W         3

// Direction bit of slot n sits at BASE + STRIDE * n
`define VSP_DIR_BIT_BASE   2
`define VSP_DIR_BIT_STRIDE 3

// Reset values
`define VSP_RST_OUT_DATA   8'h00
`define VSP_RST_IRQ_LEVEL  8'h00
`define VSP_RST_IRQ_STATE  8'h00
`define VSP_RST_RD_DATA    32'h0000_0000

// Switch number of this upstream port; value is arbitrary
`define VSP_VS_ID_DEF      4'h0

`endif

/* File: pkg/vsp_pkg.sv */
`include "vsp_cfg.svh"

package vsp_pkg;

	// One register access from the upstream port
	typedef struct packed
	{
		logic                      wr;
		logic                      rd;
		logic [`VSP_ADDR_W-1:0]    addr;
		logic [3:0]                be;
		logic [31:0]               wdata;
	} vsp_reg_req_t;

	// Assignment of one physical pin to a switch and a slot
	typedef struct packed
	{
		logic                      valid;
		logic [`VSP_OWNER_W-1:0]   owner;
		logic [`VSP_SLOT_W-1:0]    slot;
	} vsp_pin_map_t;

endpackage

/* File: verilog/vsp_pin_sync.sv */
`timescale 1ns/1ps

module vsp_pin_sync
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);
	import vsp_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// Level moves only when the second and third stages agree;
	// stage1 feeds stage2 alone to keep metastability contained
	always_comb
	begin
		for (int b = 0; b < WIDTH; b++)
		begin
			if (stage2[b] == stage3[b])
				next_level[b] = stage3[b];
			else
				next_level[b] = level_o[b];
		end
	end

	// Three-stage chain and filtered level
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			stage1  <= '0;
			stage2  <= '0;
			stage3  <= '0;
			level_o <= '0;
		end
		else
		begin
			stage1  <= pin_i;
			stage2  <= stage1;
			stage3  <= stage2;
			level_o <= next_level;
		end
	end
endmodule

/* File: verilog/vsp_pin_map.sv */
`timescale 1ns/1ps
`include "vsp_cfg.svh"

module vsp_pin_map
#(
	parameter int                      SLOT_NUM = `VSP_SLOT_NUM,
	parameter int                      PIN_NUM  = `VSP_PIN_NUM,
	parameter logic [`VSP_OWNER_W-1:0] VS_ID    = `VSP_VS_ID_DEF
)
(
	input  vsp_pkg::vsp_pin_map_t [PIN_NUM-1:0] pin_map_i,
	input  wire logic [PIN_NUM-1:0]             pin_level_i,
	output logic      [PIN_NUM-1:0]             pin_owned_o,
	output logic      [SLOT_NUM-1:0]            slot_valid_o,
	output logic      [SLOT_NUM-1:0]            slot_level_o
);
	import vsp_pkg::*;

	// A pin belongs here only when its single owner field names us,
	// so no pin can ever be seen by two switches at once
	always_comb
	begin
		for (int p = 0; p < PIN_NUM; p++)
			pin_owned_o[p] = pin_map_i[p].valid &&
				(pin_map_i[p].owner == VS_ID);
	end

	// Slot view hides the physical pin; lowest pin wins on a clash
	genvar s;
	generate
		for (s = 0; s < SLOT_NUM; s++)
		begin : g_slot
			always_comb
			begin
				slot_valid_o[s] = 1'b0;
				slot_level_o[s] = 1'b0;
				for (int p = PIN_NUM - 1; p >= 0; p--)
				begin
					if (pin_owned_o[p] &&
						(int'(pin_map_i[p].slot) == s))
					begin
						slot_valid_o[s] = 1'b1;
						slot_level_o[s] = pin_level_i[p];
					end
				end
			end
		end
	endgenerate
endmodule

/* File: verilog/vsp_shadow_pins.sv */
`timescale 1ns/1ps
`include "vsp_cfg.svh"

module vsp_shadow_pins
#(
	parameter int                      SLOT_NUM = `VSP_SLOT_NUM,
	parameter int                      PIN_NUM  = `VSP_PIN_NUM,
	parameter logic [`VSP_OWNER_W-1:0] VS_ID    = `VSP_VS_ID_DEF
)
(
	input  wire logic                           sys_clk_i,
	input  wire logic                           rst_n_i,
	input  vsp_pkg::vsp_reg_req_t               reg_req_i,
	output logic                                rd_ack_o,
	output logic                                rd_hit_o,
	output logic      [31:0]                    rd_data_o,
	input  wire logic [31:0]                    dir_cfg_i,
	input  wire logic [SLOT_NUM-1:0]            irq_mask_i,
	input  vsp_pkg::vsp_pin_map_t [PIN_NUM-1:0] pin_map_i,
	input  wire logic [PIN_NUM-1:0]             pin_in_i,
	output logic      [PIN_NUM-1:0]             pin_out_o,
	output logic      [PIN_NUM-1:0]             pin_oe_o,
	output logic      [SLOT_NUM-1:0]            irq_state_o
);
	import vsp_pkg::*;

	logic [SLOT_NUM-1:0] out_data;
	logic [SLOT_NUM-1:0] irq_level;
	logic [SLOT_NUM-1:0] next_out_data;
	logic [SLOT_NUM-1:0] next_irq_level;
	logic [SLOT_NUM-1:0] next_irq_state;
	logic [SLOT_NUM-1:0] slot_dir_out;
	logic [SLOT_NUM-1:0] slot_valid;
	logic [SLOT_NUM-1:0] slot_level;
	logic [SLOT_NUM-1:0] slot_active;
	logic [PIN_NUM-1:0]  pin_level;
	logic [PIN_NUM-1:0]  pin_owned;
	logic [PIN_NUM-1:0]  next_pin_out;
	logic [PIN_NUM-1:0]  next_pin_oe;
	logic                wr_out;
	logic                wr_level;
	logic                next_rd_ack;
	logic                next_rd_hit;
	logic [31:0]         next_rd_data;

	// Pin inputs come from the board and need the filtered chain
	vsp_pin_sync
	#(
		.WIDTH (PIN_NUM)
	)
	u_sync
	(
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.pin_i     (pin_in_i),
		.level_o   (pin_level)
	);

	// eight slots only
	// Ownership check and physical-to-slot translation
	vsp_pin_map
	#(
		.SLOT_NUM (SLOT_NUM),
		.PIN_NUM  (PIN_NUM),
		.VS_ID    (VS_ID)
	)
	u_map
	(
		.pin_map_i    (pin_map_i),
		.pin_level_i  (pin_level),
		.pin_owned_o  (pin_owned),
		.slot_valid_o (slot_valid),
		.slot_level_o (slot_level)
	);

	// direction bit select
	// Slot n reads bit 3n+2 of the neighbouring direction register
	genvar s;
	generate
		for (s = 0; s < SLOT_NUM; s++)
		begin : g_dir
			assign slot_dir_out[s] =
				dir_cfg_i[`VSP_DIR_BIT_BASE + `VSP_DIR_BIT_STRIDE * s];
		end
	endgenerate

	// Write strobes; only byte lane 0 holds live bits
	assign wr_out   = reg_req_i.wr && reg_req_i.be[0] &&
		(reg_req_i.addr == `VSP_OFS_OUT_DATA);
	assign wr_level = reg_req_i.wr && reg_req_i.be[0] &&
		(reg_req_i.addr == `VSP_OFS_IRQ_LEVEL);

	always_comb
	begin
		next_out_data  = out_data;
		next_irq_level = irq_level;
		if (wr_out)
			next_out_data = reg_req_i.wdata[SLOT_NUM-1:0];
		if (wr_level)
			next_irq_level = reg_req_i.wdata[SLOT_NUM-1:0];
	end

	// Software-loaded settings
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			out_data  <= `VSP_RST_OUT_DATA;
			irq_level <= `VSP_RST_IRQ_LEVEL;
		end
		else
		begin
			out_data  <= next_out_data;
			irq_level <= next_irq_level;
		end
	end

	// polarity applied
	// Unassigned slots never look active
	assign slot_active = slot_valid & ~(slot_level ^ irq_level);

	// frozen while masked
	// No latching: the bit tracks the pin, so it needs no clear path
	always_comb
	begin
		for (int i = 0; i < SLOT_NUM; i++)
		begin
			if (irq_mask_i[i])
				next_irq_state[i] = irq_state_o[i];
			else
				next_irq_state[i] = slot_active[i];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_state_o <= `VSP_RST_IRQ_STATE;
		else
			irq_state_o <= next_irq_state;
	end

	// only owned pins driven
	// Built from the next data so the pin moves on the write edge
	always_comb
	begin
		for (int p = 0; p < PIN_NUM; p++)
		begin
			next_pin_oe[p]  = pin_owned[p] &&
				slot_dir_out[pin_map_i[p].slot];
			next_pin_out[p] = next_pin_oe[p] &&
				next_out_data[pin_map_i[p].slot];
		end
	end

	// Registered pin drivers
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_out_o <= '0;
			pin_oe_o  <= '0;
		end
		else
		begin
			pin_out_o <= next_pin_out;
			pin_oe_o  <= next_pin_oe;
		end
	end

	always_comb
	begin
		next_rd_ack  = reg_req_i.rd;
		next_rd_hit  = 1'b0;
		next_rd_data = `VSP_RST_RD_DATA;
		if (!reg_req_i.rd)
			next_rd_hit = 1'b0;
		else if (reg_req_i.addr == `VSP_OFS_OUT_DATA)
		begin
			next_rd_hit                 = 1'b1;
			next_rd_data[SLOT_NUM-1:0]  = out_data;
		end
		else if (reg_req_i.addr == `VSP_OFS_IRQ_LEVEL)
		begin
			next_rd_hit                 = 1'b1;
			next_rd_data[SLOT_NUM-1:0]  = irq_level;
		end
		else if (reg_req_i.addr == `VSP_OFS_IRQ_STATE)
		begin
			next_rd_hit                 = 1'b1;
			next_rd_data[SLOT_NUM-1:0]  = irq_state_o;
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_ack_o  <= 1'b0;
			rd_hit_o  <= 1'b0;
			rd_data_o <= `VSP_RST_RD_DATA;
		end
		else
		begin
			rd_ack_o  <= next_rd_ack;
			rd_hit_o  <= next_rd_hit;
			rd_data_o <= next_rd_data;
		end
	end

	out_write_a:
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_out |=> out_data == $past(reg_req_i.wdata[SLOT_NUM-1:0]))
	else $error("output data write not stored");

	level_write_a:
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_level |=> irq_level == $past(reg_req_i.wdata[SLOT_NUM-1:0]))
	else $error("level select write not stored");

	upper_zero_a:
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rd_ack_o |-> rd_data_o[31:SLOT_NUM] == '0)
	else $error("upper read bits not zero");

	read_state_a:
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_req_i.rd && reg_req_i.addr == `VSP_OFS_IRQ_STATE
		|=> rd_ack_o && rd_hit_o &&
		rd_data_o[SLOT_NUM-1:0] == $past(irq_state_o))
	else $error("state read returned wrong value");

	mask_hold_a:
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 ((irq_state_o ^ $past(irq_state_o)) &
		$past(irq_mask_i)) == '0)
	else $error("masked state bit changed");

	state_ro_a:
	assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reg_req_i.wr && reg_req_i.addr == `VSP_OFS_IRQ_STATE &&
		(&irq_mask_i) |=> $stable(irq_state_o))
	else $error("state bits written by software");

	generate
		for (s = 0; s < SLOT_NUM; s++)
		begin : g_chk_slot
			state_follow_a:
			assert property (@(posedge sys_clk_i)
				disable iff (!rst_n_i)
				!irq_mask_i[s] && slot_valid[s] &&
				slot_level[s] == irq_level[s]
				|=> irq_state_o[s])
			else $error("active unmasked slot not reported");

			state_clear_a:
			assert property (@(posedge sys_clk_i)
				disable iff (!rst_n_i)
				!irq_mask_i[s] &&
				(!slot_valid[s] || slot_level[s] != irq_level[s])
				|=> !irq_state_o[s])
			else $error("inactive unmasked slot not cleared");
		end
	endgenerate

	generate
		for (genvar p = 0; p < PIN_NUM; p++)
		begin : g_chk_pin
			pin_drive_a:
			assert property (@(posedge sys_clk_i)
				disable iff (!rst_n_i)
				pin_owned[p] && slot_dir_out[pin_map_i[p].slot]
				|=> pin_oe_o[p] && pin_out_o[p] ==
				out_data[$past(pin_map_i[p].slot)])
			else $error("output slot not driven onto pin");

			pin_foreign_a:
			assert property (@(posedge sys_clk_i)
				disable iff (!rst_n_i)
				!pin_owned[p] |=> !pin_oe_o[p] && !pin_out_o[p])
			else $error("pin of another switch driven");
		end
	endgenerate
endmodule

/* File: tb/vsp_board_model.sv */
`timescale 1ns/1ps

// Board side of the shared pins: a driven pin reads back its own drive,
// an undriven pin follows the level the bench commands
module vsp_board_model
(
	input  wire logic [7:0] pin_out_i,
	input  wire logic [7:0] pin_oe_i,
	input  wire logic [7:0] level_i,
	output logic      [7:0] pin_in_o
);
	// Wire level resolved from both drivers
	assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & level_i);
endmodule

/* File: tb/vsp_shadow_pins_tb_top.sv */
`timescale 1ns/1ps
`include "vsp_cfg.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	miscompares++; $display("Error %s exp %h got %h", n, e, g); end end

module vsp_shadow_pins_tb_top;
	import vsp_pkg::*;
	logic               sys_clk_i = 1'b0;
	logic               rst_n_i = 1'b0;
	vsp_reg_req_t       req = '0;
	logic               rd_ack;
	logic               rd_hit;
	logic [31:0]        rd_data;
	logic [31:0]        dir = '0;
	logic [7:0]         mask = 8'hFF;
	logic [7:0]         lvl = '0;
	logic [7:0]         pin_in;
	logic [7:0]         pin_out;
	logic [7:0]         pin_oe;
	logic [7:0]         irq;
	vsp_pin_map_t [7:0] pmap;
	logic [32:0]        expq[$];
	logic [32:0]        e;
	logic [7:0]         dat = '0;
	logic [7:0]         pol = '0;
	logic [7:0]         st = '0;
	logic [7:0]         eo;
	logic [7:0]         ee;
	logic [7:0]         act;
	int                 miscompares = 0;
	int                 comparisons = 0;
	int                 seed = 53;

	// Free running clock
	always #2 sys_clk_i = ~sys_clk_i;

	vsp_shadow_pins uut
	(
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.reg_req_i   (req),
		.rd_ack_o    (rd_ack),
		.rd_hit_o    (rd_hit),
		.rd_data_o   (rd_data),
		.dir_cfg_i   (dir),
		.irq_mask_i  (mask),
		.pin_map_i   (pmap),
		.pin_in_i    (pin_in),
		.pin_out_o   (pin_out),
		.pin_oe_o    (pin_oe),
		.irq_state_o (irq)
	);

	vsp_board_model board
	(
		.pin_out_i (pin_out),
		.pin_oe_i  (pin_oe),
		.level_i   (lvl),
		.pin_in_o  (pin_in)
	);

	task automatic conclude();
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One register cycle, held for a single edge
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [3:0] b, input logic [31:0] d);
		@(posedge sys_clk_i);
		req <= '{w, ~w, a, b, d};
		@(posedge sys_clk_i);
		req <= '0;
	endtask

	// Note the expected {hit, data} before the read goes out
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		expq.push_back(x);
		acc(1'b0, a, 4'h0, 32'h0);
	endtask

	// Pin p serves slot 7-p, pin 7 belongs to another switch
	function automatic void model();
		int s;
		for (int p = 0; p < 8; p++)
		begin
			s = 7 - p;
			eo[p] = (p < 7) && dir[3*s+2];
			ee[p] = eo[p] & dat[s];
		end
		act = 8'h00;
		for (int k = 1; k < 8; k++)
			act[k] = ((eo[7-k] ? ee[7-k] : lvl[7-k]) == pol[k]);
		// Masked slots keep what they had
		st = (mask & st) | (~mask & act);
	endfunction

	// Let pin changes pass the sync chain, then compare
	task automatic settle();
		repeat (8) @(posedge sys_clk_i);
		model();
		`CHK("pin_oe", eo, pin_oe)
		`CHK("pin_out", ee, pin_out)
		`CHK("irq_state", st, irq)
		rd(`VSP_OFS_IRQ_STATE, {1'b1, 24'h0, st});
	endtask

	// Read answers are matched in order against the notes
	always @(posedge sys_clk_i)
		if (rd_ack === 1'b1)
		begin
			e = expq.pop_front();
			`CHK("read", e, {rd_hit, rd_data})
		end

	// Cut a hang short
	initial
	begin
		#20000;
		miscompares++;
		conclude();
	end

	// Main sequence
	initial
	begin
		for (int p = 0; p < 7; p++)
			pmap[p] <= '{1'b1, 4'h0, 3'(7 - p)};
		pmap[7] <= '{1'b1, 4'h5, 3'd0};
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(`VSP_OFS_OUT_DATA, {1'b1, 32'h0});
		rd(`VSP_OFS_IRQ_LEVEL, {1'b1, 32'h0});
		rd(12'hA74, 33'h0);
		// Write to the state word while every slot is masked
		acc(1'b1, `VSP_OFS_IRQ_STATE, 4'hF, 32'hFFFF_FFFF);
		settle();
		mask <= 8'h00;
		repeat (6)
		begin
			dat = 8'($random(seed));
			pol = 8'($random(seed));
			acc(1'b1, `VSP_OFS_OUT_DATA, 4'h1, {24'($random(seed)), dat});
			acc(1'b1, `VSP_OFS_IRQ_LEVEL, 4'h1, {24'($random(seed)), pol});
			// Refused writes: byte lane 0 not enabled, read-only place
			acc(1'b1, `VSP_OFS_OUT_DATA, 4'hE, {24'hFF_FFFF, ~dat});
			acc(1'b1, `VSP_OFS_IRQ_STATE, 4'hF, 32'hFFFF_FFFF);
			rd(`VSP_OFS_OUT_DATA, {1'b1, 24'h0, dat});
			rd(`VSP_OFS_IRQ_LEVEL, {1'b1, 24'h0, pol});
			dir <= $random(seed);
			lvl <= 8'($random(seed));
			settle();
		end
		// Mask changes together with the levels
		repeat (4)
		begin
			mask <= 8'($random(seed));
			lvl <= 8'($random(seed));
			settle();
		end
		repeat (4) @(posedge sys_clk_i);
		// Every read sent must have been answered
		`CHK("pending", 0, expq.size())
		conclude();
	end
endmodule
